// file: hdl/tfmce_pkg.sv
// constants and types of the frame multiplexer and encoder
package tfmce_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned AUDIO_HZ      = 20_000;
  localparam int unsigned PCM_HZ        = 50_000;
  localparam int unsigned AUDIO_DIV     = CLK_HZ / AUDIO_HZ;
  localparam int unsigned PCM_HALF      = CLK_HZ / (2 * PCM_HZ);
  localparam int unsigned BIT_DIV       = 4;
  localparam int unsigned BITS_PER_UNIT = 200;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam logic [29:0] SYNC_WORD  = 30'o3564622552;
  localparam logic [2:0]  GRP_SYNC0  = 3'h0;
  localparam logic [2:0]  GRP_AUDIO  = 3'h3;
  localparam logic [2:0]  GRP_PCM    = 3'h4;
  localparam logic [2:0]  GRP_TV0    = 3'h5;
  localparam logic [2:0]  GRP_TV1    = 3'h6;
  localparam logic [2:0]  GRP_TV2    = 3'h7;
  localparam logic [1:0]  FILL_BITS  = 2'h0;
  localparam logic [3:0]  DEC_LAST   = 4'h9;
  localparam logic [5:0]  PN_TAP_A   = 6'h20;
  localparam logic [5:0]  PN_TAP_B   = 6'h10;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_TAPLO  = 8'h04;
  localparam logic [7:0]  ADDR_TAPHI  = 8'h08;
  localparam logic [7:0]  ADDR_TAPSH  = 8'h0c;
  localparam logic [7:0]  ADDR_STAT   = 8'h10;
  localparam logic [3:0]  RATE_RESET  = 4'h1;
  localparam logic [39:0] TAPL_RESET  = 40'h00_0000_0000;
  localparam logic [5:0]  TAPS_RESET  = 6'h00;
  localparam int unsigned CTRL_SYS    = 4;
  localparam int unsigned CTRL_THIRD  = 5;
  localparam int unsigned CTRL_PN     = 6;
  localparam int unsigned SH_STRIDE   = 8;

  typedef struct packed {
    logic       pn_en;
    logic       third;
    logic       systematic;
    logic [3:0] rate_bcd;
  } tfmce_ctrl_t;

  typedef struct packed {
    logic [39:0] long_taps;
    logic [5:0]  short_one;
    logic [5:0]  short_two;
    logic [5:0]  short_three;
  } tfmce_taps_t;

endpackage : tfmce_pkg

// file: hdl/tfmce_top.sv
// frame multiplexer with convolutional encoder and apb registers
//
// Local design decisions: the placing of the registers and register access over APB.

// Overview of operation
// - frame opens with 30 sync bits
// - bits 31-34 carry audio channel one
// - bits 35-38 carry audio channel two
// - bits 39-40 are filler
// - bits 41-50 carry ten pcm bits
// - frame is 200 bits per selected MHz
// - three decades plus halver count frame bits
// - frame ends when third decade plus one equals rate
// - sync is constant octal 3564622552
// - audio shifters take bits at 20 kHz
// - device drives continuous 50 kHz pcm clock
// - pcm shifts into two five-bit halves
// - buffer word taken as three ten-bit groups
// - pulse buffer advance after last group
// - group counter steps every ten bits
// - load at count nine, tenth bit held
// - after header groups cycle 5,6,7
// - saved group count resumes after header
// - 40-stage register feeds four parity sums
// - systematic sends data then long parity
// - nonsystematic sends three or two parities
// - feedback option gives length 63 pn
module tfmce_top
  import tfmce_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // audio sources
  input  wire logic        audio_one_in,
  input  wire logic        audio_two_in,
  output logic             audio_clk,
  // pcm source
  input  wire logic        pcm_in,
  output logic             pcm_clk,
  // rate buffer
  input  wire logic [29:0] tv_word,
  output logic             rb_advance,
  // channel
  output logic             mux_data,
  output logic             bit_strobe,
  output logic             frame_start,
  output logic             enc_data,
  output logic             enc_valid
);
  import tfmce_pkg::*;

  // ************************************************************
  // registers and state
  // ************************************************************
  tfmce_ctrl_t ctrl_reg;
  tfmce_taps_t taps_reg;
  logic [1:0]  tick_reg;
  logic [3:0]  dec0_reg, dec1_reg, dec2_reg;
  logic        half_reg;
  logic [2:0]  grp_reg, grp_next;
  logic [1:0]  saved_reg;
  logic [9:0]  sreg_reg;
  logic [3:0]  aud1_reg, aud2_reg;
  logic [9:0]  aud_cnt_reg;
  logic [7:0]  pcm_cnt_reg;
  logic [4:0]  pcm_hi_reg, pcm_lo_reg;
  logic [39:0] enc_reg, enc_next;
  logic [2:0]  osr_reg;
  logic [1:0]  ocnt_reg;
  logic [15:0] frames_reg;
  logic        bit_tick, load, frame_end, din;
  logic [3:0]  rate_eff;
  logic        rd_en, wr_en;

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [3:0] clamp_rate(input logic [3:0] r);
    if (r == 4'h0 || r > DEC_LAST) begin
      return RATE_RESET;
    end else begin
      return r;
    end
  endfunction : clamp_rate

  function automatic logic [2:0] saved_to_grp(input logic [1:0] s);
    return GRP_TV0 + {1'b0, s};
  endfunction : saved_to_grp

  function automatic logic [9:0] grp_data(input logic [2:0] g);
    if (g == GRP_SYNC0) begin
      return SYNC_WORD[29:20];
    end else if (g == 3'h1) begin
      return SYNC_WORD[19:10];
    end else if (g == 3'h2) begin
      return SYNC_WORD[9:0];
    end else if (g == GRP_AUDIO) begin
      return {aud1_reg, aud2_reg, FILL_BITS};
    end else if (g == GRP_PCM) begin
      return {pcm_hi_reg, pcm_lo_reg};
    end else if (g == GRP_TV0) begin
      return tv_word[29:20];
    end else if (g == GRP_TV1) begin
      return tv_word[19:10];
    end else begin
      return tv_word[9:0];
    end
  endfunction : grp_data

  // ************************************************************
  // apb slave
  // ************************************************************
  assign pready  = 1'b1;
  assign rd_en   = psel && !penable && !pwrite;
  assign wr_en   = psel && penable && pwrite;
  assign pslverr = psel && penable && (paddr > ADDR_STAT || paddr[1:0] != 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '{pn_en: 1'b0, third: 1'b0, systematic: 1'b0, rate_bcd: RATE_RESET};
      taps_reg <= '{TAPL_RESET, TAPS_RESET, TAPS_RESET, TAPS_RESET};
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_reg.rate_bcd   <= pwdata[3:0];
        ctrl_reg.systematic <= pwdata[CTRL_SYS];
        ctrl_reg.third      <= pwdata[CTRL_THIRD];
        ctrl_reg.pn_en      <= pwdata[CTRL_PN];
      end else if (paddr == ADDR_TAPLO) begin
        taps_reg.long_taps[31:0] <= pwdata;
      end else if (paddr == ADDR_TAPHI) begin
        taps_reg.long_taps[39:32] <= pwdata[7:0];
      end else if (paddr == ADDR_TAPSH) begin
        taps_reg.short_one   <= pwdata[5:0];
        taps_reg.short_two   <= pwdata[SH_STRIDE +: 6];
        taps_reg.short_three <= pwdata[2*SH_STRIDE +: 6];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      if (paddr == ADDR_CTRL) begin
        prdata <= {25'h0, ctrl_reg.pn_en, ctrl_reg.third, ctrl_reg.systematic,
                   ctrl_reg.rate_bcd};
      end else if (paddr == ADDR_TAPLO) begin
        prdata <= taps_reg.long_taps[31:0];
      end else if (paddr == ADDR_TAPHI) begin
        prdata <= {24'h0, taps_reg.long_taps[39:32]};
      end else if (paddr == ADDR_TAPSH) begin
        prdata <= {10'h0, taps_reg.short_three, 2'h0, taps_reg.short_two, 2'h0,
                   taps_reg.short_one};
      end else if (paddr == ADDR_STAT) begin
        prdata <= {frames_reg, 3'h0, saved_reg, grp_reg, dec2_reg, dec1_reg};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // ************************************************************
  // information bit timing
  // ************************************************************
  assign bit_tick = (tick_reg == 2'(BIT_DIV - 1));
  assign rate_eff = clamp_rate(ctrl_reg.rate_bcd);
  assign load     = bit_tick && (dec0_reg == DEC_LAST);
  assign frame_end = load && (dec1_reg == DEC_LAST) && half_reg
                     && (dec2_reg + 4'h1 == rate_eff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 2'h0;
    end else if (bit_tick) begin
      tick_reg <= 2'h0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
    end
  end

  // ************************************************************
  // frame counter
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec0_reg <= 4'h0;
      dec1_reg <= 4'h0;
      half_reg <= 1'b0;
      dec2_reg <= 4'h0;
    end else if (frame_end) begin
      dec0_reg <= 4'h0;
      dec1_reg <= 4'h0;
      half_reg <= 1'b0;
      dec2_reg <= 4'h0;
    end else if (bit_tick) begin
      dec0_reg <= (dec0_reg == DEC_LAST) ? 4'h0 : dec0_reg + 4'h1;
      if (dec0_reg == DEC_LAST) begin
        dec1_reg <= (dec1_reg == DEC_LAST) ? 4'h0 : dec1_reg + 4'h1;
        if (dec1_reg == DEC_LAST) begin
          half_reg <= ~half_reg;
          if (half_reg) begin
            dec2_reg <= dec2_reg + 4'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames_reg  <= 16'h0;
      frame_start <= 1'b0;
    end else begin
      frame_start <= frame_end;
      if (frame_end) begin
        frames_reg <= frames_reg + 16'h1;
      end
    end
  end

  // ************************************************************
  // group counter
  // ************************************************************
  always_comb begin
    if (frame_end) begin
      grp_next = GRP_SYNC0;
    end else if (grp_reg == GRP_PCM) begin
      grp_next = saved_to_grp(saved_reg);
    end else if (grp_reg == GRP_TV2) begin
      grp_next = GRP_TV0;
    end else begin
      grp_next = grp_reg + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_reg   <= GRP_SYNC0;
      saved_reg <= 2'h0;
    end else if (load) begin
      grp_reg <= grp_next;
      if (frame_end) begin
        saved_reg <= (grp_reg == GRP_TV2) ? 2'h0 : 2'(grp_reg - GRP_TV0 + 3'h1);
      end
    end
  end

  // ************************************************************
  // output shift register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sreg_reg   <= SYNC_WORD[29:20];
      mux_data   <= 1'b0;
      bit_strobe <= 1'b0;
      rb_advance <= 1'b0;
    end else begin
      bit_strobe <= bit_tick;
      rb_advance <= load && (grp_next == GRP_TV2);
      if (bit_tick) begin
        mux_data <= sreg_reg[9];
        if (load) begin
          sreg_reg <= grp_data(grp_next);
        end else begin
          sreg_reg <= {sreg_reg[8:0], 1'b0};
        end
      end
    end
  end

  // ************************************************************
  // audio and pcm inputs
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aud_cnt_reg <= 10'h0;
      audio_clk   <= 1'b0;
      aud1_reg    <= 4'h0;
      aud2_reg    <= 4'h0;
    end else begin
      audio_clk <= (aud_cnt_reg == 10'(AUDIO_DIV - 1));
      if (aud_cnt_reg == 10'(AUDIO_DIV - 1)) begin
        aud_cnt_reg <= 10'h0;
        aud1_reg    <= {aud1_reg[2:0], audio_one_in};
        aud2_reg    <= {aud2_reg[2:0], audio_two_in};
      end else begin
        aud_cnt_reg <= aud_cnt_reg + 10'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_cnt_reg <= 8'h0;
      pcm_clk     <= 1'b0;
      pcm_hi_reg  <= 5'h0;
      pcm_lo_reg  <= 5'h0;
    end else if (pcm_cnt_reg == 8'(PCM_HALF - 1)) begin
      pcm_cnt_reg <= 8'h0;
      pcm_clk     <= ~pcm_clk;
      if (!pcm_clk) begin
        pcm_hi_reg <= {pcm_hi_reg[3:0], pcm_lo_reg[4]};
        pcm_lo_reg <= {pcm_lo_reg[3:0], pcm_in};
      end
    end else begin
      pcm_cnt_reg <= pcm_cnt_reg + 8'h1;
    end
  end

  // ************************************************************
  // convolutional encoder
  // ************************************************************
  assign din      = ctrl_reg.pn_en
                    ? ~(^(enc_reg[5:0] & (PN_TAP_A | PN_TAP_B)))
                    : mux_data;
  assign enc_next = {enc_reg[38:0], din};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_reg   <= 40'h0;
      osr_reg   <= 3'h0;
      ocnt_reg  <= 2'h0;
      enc_data  <= 1'b0;
      enc_valid <= 1'b0;
    end else if (bit_tick) begin
      enc_reg   <= enc_next;
      enc_valid <= 1'b0;
      if (ctrl_reg.systematic) begin
        osr_reg  <= {din, ^(enc_next & taps_reg.long_taps), 1'b0};
        ocnt_reg <= 2'h2;
      end else begin
        osr_reg  <= {^(enc_next[5:0] & taps_reg.short_one),
                     ^(enc_next[5:0] & taps_reg.short_two),
                     ^(enc_next[5:0] & taps_reg.short_three)};
        ocnt_reg <= ctrl_reg.third ? 2'h3 : 2'h2;
      end
    end else if (ocnt_reg != 2'h0) begin
      enc_data  <= osr_reg[2];
      enc_valid <= 1'b1;
      osr_reg   <= {osr_reg[1:0], 1'b0};
      ocnt_reg  <= ocnt_reg - 2'h1;
    end else begin
      enc_valid <= 1'b0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_sync_load : assert property (@(posedge pclk) disable iff (!presetn)
    load && grp_next == GRP_SYNC0 |=> sreg_reg == SYNC_WORD[29:20])
    else $error("sync head not loaded");
  a_audio_fill : assert property (@(posedge pclk) disable iff (!presetn)
    load && grp_next == GRP_AUDIO |=>
      sreg_reg == {$past(aud1_reg), $past(aud2_reg), 2'h0})
    else $error("audio group wrong");
  a_pcm_group : assert property (@(posedge pclk) disable iff (!presetn)
    load && grp_next == GRP_PCM |=> sreg_reg == {$past(pcm_hi_reg), $past(pcm_lo_reg)})
    else $error("pcm group wrong");
  a_frame_len : assert property (@(posedge pclk) disable iff (!presetn)
    frame_end |-> (dec2_reg * 200 + half_reg * 100 + dec1_reg * 10 + dec0_reg)
                  == rate_eff * 200 - 1)
    else $error("frame length wrong");
  a_tv_cycle : assert property (@(posedge pclk) disable iff (!presetn)
    load && !frame_end && grp_reg >= GRP_TV0 |-> grp_next >= GRP_TV0)
    else $error("tv groups left early");
  a_grp_resume : assert property (@(posedge pclk) disable iff (!presetn)
    load && grp_reg == GRP_PCM |=> grp_reg == GRP_TV0 + {1'b0, $past(saved_reg)})
    else $error("group did not resume");
  a_buf_pulse : assert property (@(posedge pclk) disable iff (!presetn)
    rb_advance |-> $past(load) && grp_reg == GRP_TV2 ##1 !rb_advance)
    else $error("buffer pulse misplaced");
  a_grp_step : assert property (@(posedge pclk) disable iff (!presetn)
    !$stable(grp_reg) |-> $past(bit_tick) && $past(dec0_reg) == DEC_LAST)
    else $error("group stepped off count nine");
  a_sys_order : assert property (@(posedge pclk) disable iff (!presetn)
    bit_tick && ctrl_reg.systematic |=> ##1 enc_valid && enc_data == $past(din, 2)
      ##1 enc_valid ##1 !enc_valid)
    else $error("systematic order wrong");

endmodule : tfmce_top

// file: tb/tfmce_src_model.sv
// source model: audio channels, pcm unit and rate buffer
module tfmce_src_model (
  // clock, reset and bench levels
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [2:0]  lvl,
  input  wire logic [29:0] nxt,
  // audio and pcm
  input  wire logic        audio_clk,
  input  wire logic        pcm_clk,
  output logic             audio_one_in,
  output logic             audio_two_in,
  output logic             pcm_in,
  // rate buffer
  input  wire logic        rb_advance,
  output logic [29:0]      tv_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pcm_clk_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      audio_one_in <= lvl[2];
      audio_two_in <= lvl[1];
    end else if (audio_clk) begin
      audio_one_in <= lvl[2];
      audio_two_in <= lvl[1];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_clk_d <= 1'b0;
      pcm_in    <= lvl[0];
    end else begin
      pcm_clk_d <= pcm_clk;
      if (pcm_clk_d && !pcm_clk) begin
        pcm_in <= lvl[0];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tv_word <= nxt;
    end else if (rb_advance) begin
      tv_word <= nxt;
    end
  end
endmodule : tfmce_src_model

// file: tb/tfmce_top_tb.sv
// testbench of the frame multiplexer and encoder
module tfmce_top_tb
  import tfmce_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hbbbd8cf8, tv_seed = 32'hbbbd8cf8;
  logic        pready, pslverr, audio_one_in, audio_two_in, audio_clk, pcm_in, pcm_clk;
  logic        rb_advance, mux_data, bit_strobe, frame_start, enc_data, enc_valid, err;
  logic        fields_ok = 1'b0, last_bit = 1'b0;
  logic [29:0] tv_word, nxt = 30'h3bbd8cf8;
  int          aud_gap = -1, pcm_gap = -1;
  logic        pcm_last = 1'b0;
  logic [2:0]  lvl, syms;
  logic [39:0] sr = 40'h0;
  int          mismatches = 0, comparisons = 0, sym_i = 0, n_exp = 0;
  logic        q_bits[$];
  logic [31:0] tv_q[$];
  tfmce_ctrl_t cc = {3'b000, RATE_RESET}, cd = {3'b000, RATE_RESET};
  tfmce_taps_t ct = '0, dt = '0;
  logic [31:0] mode[5] = '{32'h02, 32'h29, 32'h10, 32'h6c, 32'h51};
  logic [7:0]  ra[4] = '{ADDR_CTRL, ADDR_TAPLO, ADDR_TAPHI, ADDR_TAPSH};
  logic [31:0] rv[4] = '{{28'h0, RATE_RESET}, 32'h0, 32'h0, 32'h0};
  logic [7:0]  ba[2] = '{8'h14, 8'h02};

  always #25 pclk = ~pclk;

  tfmce_top u_tfmce_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .audio_one_in(audio_one_in), .audio_two_in(audio_two_in),
    .audio_clk(audio_clk), .pcm_in(pcm_in), .pcm_clk(pcm_clk), .tv_word(tv_word),
    .rb_advance(rb_advance), .mux_data(mux_data), .bit_strobe(bit_strobe),
    .frame_start(frame_start), .enc_data(enc_data), .enc_valid(enc_valid));

  tfmce_src_model u_tfmce_src_model (.pclk(pclk), .presetn(presetn), .lvl(lvl), .nxt(nxt),
    .audio_clk(audio_clk), .pcm_clk(pcm_clk), .audio_one_in(audio_one_in),
    .audio_two_in(audio_two_in), .pcm_in(pcm_in), .rb_advance(rb_advance), .tv_word(tv_word));

  // ********************************
  // helpers
  // ********************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  function automatic logic [31:0] grab(input int s, input int n);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < n; i++) v = {v[30:0], q_bits[s + i]};
    return v;
  endfunction : grab

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) chk(32'h0, 32'h1, "apb timeout");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_frame();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (frame_start !== 1'b1 && n < 20000);
    if (n >= 20000) chk(32'h0, 32'h1, "frame timeout");
  endtask : wait_frame

  task automatic check_frame();
    int r;
    r = (cc.rate_bcd == 4'h0 || cc.rate_bcd > 4'h9) ? 1 : int'(cc.rate_bcd);
    chk(32'(q_bits.size()), 32'(200 * r), "frame length");
    chk(grab(0, 30), {2'b00, SYNC_WORD}, "sync");
    chk(grab(38, 2), {30'h0, FILL_BITS}, "fill");
    if (fields_ok) begin
      chk(grab(30, 4), {28'h0, {4{lvl[2]}}}, "audio one");
      chk(grab(34, 4), {28'h0, {4{lvl[1]}}}, "audio two");
      chk(grab(40, 10), {22'h0, {10{lvl[0]}}}, "pcm");
    end
    for (int g = 50; g < q_bits.size(); g += 10) begin
      chk(grab(g, 10), tv_q.pop_front(), "tv group");
    end
  endtask : check_frame

  // ********************************
  // reference model and monitor
  // ********************************
  always @(posedge pclk) begin
    if (presetn) begin
      if (bit_strobe) begin
        chk(32'(sym_i), 32'(n_exp), "symbol count");
        sr = {sr[38:0], cd.pn_en ? ~(sr[5] ^ sr[4]) : last_bit};
        last_bit = mux_data;
        syms[0] = cd.systematic ? sr[0] : ^(sr[5:0] & dt.short_one);
        syms[1] = cd.systematic ? ^(sr & dt.long_taps) : ^(sr[5:0] & dt.short_two);
        syms[2] = ^(sr[5:0] & dt.short_three);
        n_exp = (!cd.systematic && cd.third) ? 3 : 2;
        sym_i = 0;
        q_bits.push_back(mux_data);
        if (frame_start) begin
          check_frame();
          q_bits.delete();
        end
      end
      if (enc_valid) begin
        chk({31'h0, enc_data}, {31'h0, syms[sym_i]}, "symbol");
        sym_i++;
      end
      if (rb_advance) begin
        for (int k = 2; k >= 0; k--) tv_q.push_back(32'(nxt[k*10 +: 10]));
        tv_seed = lfsr(tv_seed);
        nxt <= tv_seed[29:0];
      end
      if (audio_clk) begin
        if (aud_gap >= 0) chk(32'(aud_gap), 32'(AUDIO_DIV), "audio clock period");
        aud_gap = 1;
      end else if (aud_gap >= 0) begin
        aud_gap++;
      end
      if (pcm_clk !== pcm_last) begin
        if (pcm_gap >= 0) chk(32'(pcm_gap), 32'(PCM_HALF), "pcm half period");
        pcm_gap = 1;
        pcm_last = pcm_clk;
      end else if (pcm_gap >= 0) begin
        pcm_gap++;
      end
      cd = cc;
      dt = ct;
      if (psel && penable && pwrite) begin
        case (paddr)
          ADDR_CTRL:  cc = {pwdata[CTRL_PN], pwdata[CTRL_THIRD], pwdata[CTRL_SYS], pwdata[3:0]};
          ADDR_TAPLO: ct.long_taps[31:0] = pwdata;
          ADDR_TAPHI: ct.long_taps[39:32] = pwdata[7:0];
          ADDR_TAPSH: ct[17:0] = {pwdata[5:0], pwdata[13:8], pwdata[21:16]};
          default: ;
        endcase
      end
    end
  end

  // ********************************
  // tests
  // ********************************
  initial begin
    lvl = seed[2:0];
    for (int k = 2; k >= 0; k--) tv_q.push_back(32'(seed[k*10 +: 10]));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i], "reset value");
      chk({31'h0, err}, 32'h0, "accepted read");
    end
    apb(1'b1, ADDR_TAPSH, 32'hffffffff);
    apb(1'b0, ADDR_TAPSH, 32'h0);
    chk(rd, 32'h003f3f3f, "short taps");
    foreach (ba[i]) begin
      apb(1'b1, ba[i], 32'hffffffff);
      chk({31'h0, err}, 32'h1, "refused write");
      apb(1'b0, ba[i], 32'h0);
      chk(rd, 32'h0, "refused read");
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      apb(1'b1, ADDR_TAPLO + 8'(4 * i), seed);
    end
    repeat (5000) @(posedge pclk);
    fields_ok <= 1'b1;
    foreach (mode[i]) begin
      wait_frame();
      apb(1'b1, ADDR_CTRL, mode[i]);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, mode[i], "control readback");
      repeat (3) wait_frame();
      $display("test mode %h done", mode[i]);
    end
    report_and_stop();
  end

  initial begin
    #4_000_000;
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : tfmce_top_tb
